// [design/fct_timer.sv]
// Free-running 16-bit timer, two compares, four captures, 8-bit CPU port
`timescale 1ns/1ps
`include "fct_map.svh"
module fct_timer
   import fct_pkg::*;
#(
   parameter logic [15:0] CMP_RESET = 16'hffff
) (
   input logic clk_sys,
   input logic sys_rst,
   input logic low_power_entry,
   input logic [3:0] reg_addr,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input logic capture_pin_first,
   input logic capture_pin_second,
   input logic capture_pin_third,
   input logic capture_pin_fourth,
   input logic ext_count_pin,
   output logic compare_pin_first,
   output logic compare_pin_second,
   output logic timer_irq
);
   fct_word_t count_reg, count_next;
   fct_word_t cmp_a_reg, cmp_a_next;
   fct_word_t cmp_b_reg, cmp_b_next;
   fct_word_t cap_reg [0:3];
   fct_word_t cap_next [0:3];
   logic [7:0] hold_reg, hold_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [7:0] edge_ctrl_reg, edge_ctrl_next;
   logic [4:0] out_ctrl_reg, out_ctrl_next;
   logic [7:0] flags_reg, flags_next;
   logic [7:1] armed_reg, armed_next;
   logic [7:1] irq_en_reg, irq_en_next;
   logic [3:0] cap_pend_reg, cap_pend_next;
   logic lvl_a_reg, lvl_a_next;
   logic lvl_b_reg, lvl_b_next;
   logic pin_a_reg, pin_a_next;
   logic pin_b_reg, pin_b_next;
   logic irq_reg, irq_next;
   logic [4:0] pin_rise, pin_fall;
   logic [3:0] pick, block, fire;
   logic [7:1] flag_set, flag_clr;
   logic tick, match_a, match_b, wrap, buf_a, buf_b, wr_flags;

   // Upper-byte address of capture register idx
   function automatic logic cap_hi(input logic [3:0] a, input logic [1:0] idx);
      cap_hi = (a == (`FCT_ADDR_CAP0_HI + {1'b0, idx, 1'b0}));
   endfunction : cap_hi

   // Lower-byte address of capture register idx
   function automatic logic cap_lo(input logic [3:0] a, input logic [1:0] idx);
      cap_lo = (a == (`FCT_ADDR_CAP0_HI + {1'b0, idx, 1'b1}));
   endfunction : cap_lo

   fct_pin_edge #(
      .WIDTH(5)
   ) u_pins (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pin_in({ext_count_pin, capture_pin_fourth, capture_pin_third,
               capture_pin_second, capture_pin_first}),
      .pin_rise(pin_rise),
      .pin_fall(pin_fall)
   );

   fct_count_tick u_tick (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .hold(low_power_entry),
      .src(fct_src_t'(edge_ctrl_reg[1:0])),
      .ext_rise(pin_rise[4]),
      .tick(tick)
   );

   assign buf_a = edge_ctrl_reg[`FCT_BUF_FIRST_BIT];
   assign buf_b = edge_ctrl_reg[`FCT_BUF_SECOND_BIT];

   // Edge choice per capture channel
   for (genvar i = 0; i < 4; i++) begin : g_pick
      assign pick[i] = edge_ctrl_reg[7-i] ? pin_rise[i] : pin_fall[i];
   end

   // A capture landing on an upper-byte read waits one clock so the pair stays whole
   assign block[0] = reg_rd && (cap_hi(reg_addr, 2'd0) || (buf_a && cap_hi(reg_addr, 2'd2)));
   assign block[2] = reg_rd && (cap_hi(reg_addr, 2'd2) || (buf_a && cap_hi(reg_addr, 2'd0)));
   assign block[1] = reg_rd && (cap_hi(reg_addr, 2'd1) || (buf_b && cap_hi(reg_addr, 2'd3)));
   assign block[3] = reg_rd && (cap_hi(reg_addr, 2'd3) || (buf_b && cap_hi(reg_addr, 2'd1)));
   assign fire = (pick | cap_pend_reg) & ~block;

   // Match only on the tick that moves the count off the equal value
   assign match_a = tick && (count_reg == cmp_a_reg);
   assign match_b = tick && (count_reg == cmp_b_reg);
   assign wrap = tick && (count_reg == 16'hffff) &&
                 !(match_a && flags_reg[`FCT_CLR_ON_MATCH_BIT]);

   // Counter, compare values and capture registers
   always_comb begin
      count_next = count_reg;
      cmp_a_next = cmp_a_reg;
      cmp_b_next = cmp_b_reg;
      for (int k = 0; k < 4; k++) begin
         cap_next[k] = cap_reg[k];
      end
      if (tick) begin
         if (match_a && flags_reg[`FCT_CLR_ON_MATCH_BIT]) begin
            count_next = 16'h0000;
         end else begin
            count_next = count_reg + 16'h0001;
         end
      end
      // Lower-byte write commits the latched upper byte
      if (reg_wr && reg_addr == `FCT_ADDR_COUNT_LO) begin
         count_next = {hold_reg, reg_wdata};
      end
      if (reg_wr && reg_addr == `FCT_ADDR_CMP_LO) begin
         if (out_ctrl_reg[`FCT_CMP_SEL_BIT]) begin
            cmp_b_next = {hold_reg, reg_wdata};
         end else begin
            cmp_a_next = {hold_reg, reg_wdata};
         end
      end
      if (fire[0]) begin
         if (buf_a) begin
            cap_next[2] = cap_reg[0];
         end
         cap_next[0] = count_reg;
      end
      if (fire[1]) begin
         if (buf_b) begin
            cap_next[3] = cap_reg[1];
         end
         cap_next[1] = count_reg;
      end
      if (fire[2] && !buf_a) begin
         cap_next[2] = count_reg;
      end
      if (fire[3] && !buf_b) begin
         cap_next[3] = count_reg;
      end
      if (low_power_entry) begin
         count_next = 16'h0000;
         cmp_a_next = CMP_RESET;
         cmp_b_next = CMP_RESET;
         for (int k = 0; k < 4; k++) begin
            cap_next[k] = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         count_reg <= 16'h0000;
         cmp_a_reg <= CMP_RESET;
         cmp_b_reg <= CMP_RESET;
         for (int k = 0; k < 4; k++) begin
            cap_reg[k] <= 16'h0000;
         end
      end else begin
         count_reg <= count_next;
         cmp_a_reg <= cmp_a_next;
         cmp_b_reg <= cmp_b_next;
         for (int k = 0; k < 4; k++) begin
            cap_reg[k] <= cap_next[k];
         end
      end
   end

   // Flags: hardware sets, read-then-write-zero clears, set wins
   assign wr_flags = reg_wr && reg_addr == `FCT_ADDR_FLAGS;
   assign flag_set = {fire[0], fire[1], fire[2], fire[3], match_a, match_b, wrap};
   assign flag_clr = wr_flags ? (armed_reg & ~reg_wdata[7:1]) : 7'h00;

   always_comb begin
      flags_next = flags_reg;
      flags_next[7:1] = (flags_reg[7:1] & ~flag_clr) | flag_set;
      if (wr_flags) begin
         flags_next[`FCT_CLR_ON_MATCH_BIT] = reg_wdata[`FCT_CLR_ON_MATCH_BIT];
      end
      // Only flags seen as one by a read may later be cleared
      if (reg_rd && reg_addr == `FCT_ADDR_FLAGS) begin
         armed_next = flags_reg[7:1];
      end else begin
         armed_next = armed_reg & flags_next[7:1];
      end
      cap_pend_next = (pick | cap_pend_reg) & block;
      if (low_power_entry) begin
         flags_next = `FCT_FLAGS_RST;
         armed_next = 7'h00;
         cap_pend_next = 4'h0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         flags_reg <= `FCT_FLAGS_RST;
         armed_reg <= 7'h00;
         cap_pend_reg <= 4'h0;
      end else begin
         flags_reg <= flags_next;
         armed_reg <= armed_next;
         cap_pend_reg <= cap_pend_next;
      end
   end

   // Control registers, compare pins and interrupt line
   always_comb begin
      edge_ctrl_next = edge_ctrl_reg;
      out_ctrl_next = out_ctrl_reg;
      irq_en_next = irq_en_reg;
      if (reg_wr && reg_addr == `FCT_ADDR_EDGE_CTRL) begin
         edge_ctrl_next = reg_wdata;
      end
      if (reg_wr && reg_addr == `FCT_ADDR_OUT_CTRL) begin
         out_ctrl_next = reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `FCT_ADDR_IRQ_EN) begin
         irq_en_next = reg_wdata[7:1];
      end
      lvl_a_next = match_a ? out_ctrl_reg[`FCT_LEVEL_FIRST_BIT] : lvl_a_reg;
      lvl_b_next = match_b ? out_ctrl_reg[`FCT_LEVEL_SECOND_BIT] : lvl_b_reg;
      if (low_power_entry) begin
         edge_ctrl_next = `FCT_EDGE_CTRL_RST;
         out_ctrl_next = `FCT_OUT_CTRL_RST;
         irq_en_next = `FCT_IRQ_EN_RST;
         lvl_a_next = 1'b0;
         lvl_b_next = 1'b0;
      end
      pin_a_next = out_ctrl_next[`FCT_PIN_ON_FIRST_BIT] & lvl_a_next;
      pin_b_next = out_ctrl_next[`FCT_PIN_ON_SECOND_BIT] & lvl_b_next;
      irq_next = |(flags_next[7:1] & irq_en_next);
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         edge_ctrl_reg <= `FCT_EDGE_CTRL_RST;
         out_ctrl_reg <= `FCT_OUT_CTRL_RST;
         irq_en_reg <= `FCT_IRQ_EN_RST;
         lvl_a_reg <= 1'b0;
         lvl_b_reg <= 1'b0;
         pin_a_reg <= 1'b0;
         pin_b_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         edge_ctrl_reg <= edge_ctrl_next;
         out_ctrl_reg <= out_ctrl_next;
         irq_en_reg <= irq_en_next;
         lvl_a_reg <= lvl_a_next;
         lvl_b_reg <= lvl_b_next;
         pin_a_reg <= pin_a_next;
         pin_b_reg <= pin_b_next;
         irq_reg <= irq_next;
      end
   end

   // Read path and the shared holding latch
   always_comb begin
      rdata_next = rdata_reg;
      hold_next = hold_reg;
      if (reg_wr && (reg_addr == `FCT_ADDR_COUNT_HI || reg_addr == `FCT_ADDR_CMP_HI)) begin
         hold_next = reg_wdata;
      end
      if (reg_rd) begin
         rdata_next = 8'h00;
         if (reg_addr == `FCT_ADDR_COUNT_HI) begin
            rdata_next = count_reg[15:8];
            hold_next = count_reg[7:0];
         end else if (reg_addr == `FCT_ADDR_COUNT_LO) begin
            rdata_next = hold_reg;
         end else if (reg_addr == `FCT_ADDR_CMP_HI) begin
            rdata_next = out_ctrl_reg[`FCT_CMP_SEL_BIT] ? cmp_b_reg[15:8] : cmp_a_reg[15:8];
         end else if (reg_addr == `FCT_ADDR_CMP_LO) begin
            rdata_next = out_ctrl_reg[`FCT_CMP_SEL_BIT] ? cmp_b_reg[7:0] : cmp_a_reg[7:0];
         end else if (reg_addr == `FCT_ADDR_IRQ_EN) begin
            rdata_next = {irq_en_reg, 1'b0} | `FCT_IRQ_EN_FIXED;
         end else if (reg_addr == `FCT_ADDR_EDGE_CTRL) begin
            rdata_next = edge_ctrl_reg;
         end else if (reg_addr == `FCT_ADDR_OUT_CTRL) begin
            rdata_next = `FCT_OUT_CTRL_FIXED | {3'b000, out_ctrl_reg};
         end else if (reg_addr == `FCT_ADDR_FLAGS) begin
            rdata_next = flags_reg;
         end else begin
            for (int k = 0; k < 4; k++) begin
               if (cap_hi(reg_addr, 2'(k))) begin
                  rdata_next = cap_reg[k][15:8];
                  hold_next = cap_reg[k][7:0];
               end else if (cap_lo(reg_addr, 2'(k))) begin
                  rdata_next = hold_reg;
               end
            end
         end
      end
   end

   // Holding latch is not touched by low-power entry; software rewrites both bytes
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= 8'h00;
         hold_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
         hold_reg <= hold_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign compare_pin_first = pin_a_reg;
   assign compare_pin_second = pin_b_reg;
   assign timer_irq = irq_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_count_hi_read;
      reg_rd && reg_addr == `FCT_ADDR_COUNT_HI;
   endsequence
   sequence s_count_lo_read;
      reg_rd && reg_addr == `FCT_ADDR_COUNT_LO;
   endsequence

   AST_HOLD_READ: assert property (
      s_count_hi_read ##1 !reg_rd && !reg_wr ##1 s_count_lo_read
      |=> reg_rdata == $past(count_reg[7:0], 3))
      else $error("lower count byte not from latch");
   AST_WRAP_FLAG: assert property (
      wrap && !low_power_entry && !(reg_wr && reg_addr == `FCT_ADDR_COUNT_LO)
      |=> flags_reg[`FCT_FLAG_WRAP] && count_reg == 16'h0000)
      else $error("wrap flag not set on rollover");
   AST_MATCH_FLAGS: assert property (
      (match_a || match_b) && !low_power_entry |=>
      (flags_reg[`FCT_FLAG_MATCH_FIRST] || !$past(match_a)) &&
      (flags_reg[`FCT_FLAG_MATCH_SECOND] || !$past(match_b)))
      else $error("match flag missing");
   AST_CLEAR_ON_MATCH: assert property (
      match_a && flags_reg[`FCT_CLR_ON_MATCH_BIT] && !reg_wr && !low_power_entry
      |=> count_reg == 16'h0000)
      else $error("count not cleared on match");
   AST_NO_SW_SET: assert property (
      1'b1 |=> (flags_reg[7:1] & ~$past(flags_reg[7:1]) & ~$past(flag_set)) == 7'h00)
      else $error("flag rose without an event");
   AST_OUT_FIXED: assert property (
      reg_rd && reg_addr == `FCT_ADDR_OUT_CTRL |=> reg_rdata[7:5] == 3'b111)
      else $error("fixed bits not read as one");
   AST_LOW_POWER: assert property (
      low_power_entry |=> edge_ctrl_reg == 8'h00 && out_ctrl_reg == 5'h00 && !compare_pin_first)
      else $error("control not reset on low-power entry");
   AST_CAPTURE_LOAD: assert property (
      fire[1] && !low_power_entry |=> cap_reg[1] == $past(count_reg) && flags_reg[6])
      else $error("capture second not loaded");
   AST_BUFFER_SHIFT: assert property (
      fire[0] && buf_a && !low_power_entry |=> cap_reg[2] == $past(cap_reg[0]))
      else $error("buffer did not take old value");
   AST_FOURTH_FLAG_BUFFERED: assert property (
      fire[3] && buf_b && !fire[1] && !low_power_entry
      |=> flags_reg[4] && $stable(cap_reg[3]))
      else $error("fourth capture flag or buffer wrong");
   AST_PIN_LEVEL: assert property (
      match_a && out_ctrl_reg[`FCT_PIN_ON_FIRST_BIT] && !reg_wr && !low_power_entry
      |=> compare_pin_first == $past(out_ctrl_reg[`FCT_LEVEL_FIRST_BIT]))
      else $error("compare pin level wrong");
   AST_IRQ: assert property (
      |(flags_reg[7:1] & irq_en_reg) |-> timer_irq)
      else $error("interrupt missing for enabled flag");

endmodule : fct_timer

// [design/fct_map.svh]
// Register addresses, field positions, reset values and divider masks of the timer
`ifndef FCT_MAP_SVH
`define FCT_MAP_SVH

// Byte addresses on the 8-bit peripheral port
`define FCT_ADDR_COUNT_HI 4'h0
`define FCT_ADDR_COUNT_LO 4'h1
`define FCT_ADDR_CMP_HI 4'h2
`define FCT_ADDR_CMP_LO 4'h3
`define FCT_ADDR_CAP0_HI 4'h4
`define FCT_ADDR_IRQ_EN 4'hc
`define FCT_ADDR_EDGE_CTRL 4'hd
`define FCT_ADDR_OUT_CTRL 4'he
`define FCT_ADDR_FLAGS 4'hf

// Edge/buffer/clock control fields
`define FCT_BUF_FIRST_BIT 3
`define FCT_BUF_SECOND_BIT 2
`define FCT_EDGE_CTRL_RST 8'h00

// Compare output control fields; bits 7 to 5 are fixed ones
`define FCT_CMP_SEL_BIT 4
`define FCT_PIN_ON_FIRST_BIT 3
`define FCT_PIN_ON_SECOND_BIT 2
`define FCT_LEVEL_FIRST_BIT 1
`define FCT_LEVEL_SECOND_BIT 0
`define FCT_OUT_CTRL_RST 5'h00
`define FCT_OUT_CTRL_FIXED 8'he0

// Flag register fields; bit 0 is the clear-on-match control
`define FCT_FLAG_MATCH_FIRST 3
`define FCT_FLAG_MATCH_SECOND 2
`define FCT_FLAG_WRAP 1
`define FCT_CLR_ON_MATCH_BIT 0
`define FCT_FLAGS_RST 8'h00

// Interrupt enable, bits 7 to 1 writable, bit 0 reads one
`define FCT_IRQ_EN_RST 7'h00
`define FCT_IRQ_EN_FIXED 8'h01

// Prescaler masks: tick when the masked count is all ones
`define FCT_DIV2_MASK 5'h01
`define FCT_DIV8_MASK 5'h07
`define FCT_DIV32_MASK 5'h1f

`endif

// [design/fct_pkg.sv]
// Types shared by the timer modules
package fct_pkg;

   // Count source selection codes
   typedef enum logic [1:0] {
      FCT_SRC_DIV2,
      FCT_SRC_DIV8,
      FCT_SRC_DIV32,
      FCT_SRC_EXT
   } fct_src_t;

   typedef logic [15:0] fct_word_t;

endpackage : fct_pkg

// [design/fct_pin_edge.sv]
// Two-flop pin synchroniser with rise and fall strobes
`timescale 1ns/1ps
module fct_pin_edge #(
   parameter int WIDTH = 5
) (
   input logic clk_sys,
   input logic sys_rst,
   input logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_rise,
   output logic [WIDTH-1:0] pin_fall
);
   logic [WIDTH-1:0] sync1_reg, sync1_next;
   logic [WIDTH-1:0] sync2_reg, sync2_next;
   logic [WIDTH-1:0] prev_reg, prev_next;

   // First stage feeds only the second stage
   always_comb begin
      sync1_next = pin_in;
      sync2_next = sync1_reg;
      prev_next = sync2_reg;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg <= '0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg <= prev_next;
      end
   end

   // Edge strobes from the settled stages only
   assign pin_rise = sync2_reg & ~prev_reg;
   assign pin_fall = ~sync2_reg & prev_reg;

endmodule : fct_pin_edge

// [design/fct_count_tick.sv]
// Count tick generator: system clock prescaler or external edge
`timescale 1ns/1ps
`include "fct_map.svh"
module fct_count_tick
   import fct_pkg::*;
(
   input logic clk_sys,
   input logic sys_rst,
   input logic hold,
   input fct_src_t src,
   input logic ext_rise,
   output logic tick
);
   logic [4:0] div_reg, div_next;

   // Free prescaler; held at zero in low-power modes
   always_comb begin
      div_next = hold ? 5'h00 : div_reg + 5'h01;
      case (src)
         FCT_SRC_DIV2: tick = ~hold && ((div_reg & `FCT_DIV2_MASK) == `FCT_DIV2_MASK);
         FCT_SRC_DIV8: tick = ~hold && ((div_reg & `FCT_DIV8_MASK) == `FCT_DIV8_MASK);
         FCT_SRC_DIV32: tick = ~hold && ((div_reg & `FCT_DIV32_MASK) == `FCT_DIV32_MASK);
         default: tick = ~hold && ext_rise;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         div_reg <= 5'h00;
      end else begin
         div_reg <= div_next;
      end
   end

endmodule : fct_count_tick

// [verif/fct_cpu_model.sv]
// CPU side of the 8-bit peripheral port, byte and word access tasks
`timescale 1ns/1ps
module fct_cpu_model (
   input wire logic clk_sys,
   input wire logic [7:0] reg_rdata,
   output logic [3:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   // Idle bus at time zero
   initial begin
      reg_addr = 4'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // Byte write; data inverted once released so stale bytes never look valid
   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr8
   // Byte read; data lands one cycle after the strobe edge
   task automatic rd8(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd8
   // Word access, always upper byte first
   task automatic wr16(input logic [3:0] a, input logic [15:0] v);
      wr8(a, v[15:8]);
      wr8(a + 4'h1, v[7:0]);
   endtask : wr16
   task automatic rd16(input logic [3:0] a, output logic [15:0] v);
      rd8(a, v[15:8]);
      rd8(a + 4'h1, v[7:0]);
   endtask : rd16
endmodule : fct_cpu_model

// [verif/fct_timer_tb.sv]
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`include "fct_map.svh"
module fct_timer_tb;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic lp = 1'b0;
   logic cp1 = 1'b0;
   logic cp2 = 1'b0;
   logic cp3 = 1'b0;
   logic cp4 = 1'b1;
   logic ext = 1'b0;
   logic [3:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic pin1;
   logic pin2;
   logic irq;
   logic [7:0] x;
   logic [15:0] w;
   logic [15:0] w2;
   logic [15:0] a;
   logic [15:0] b;
   integer seed = 99;
   int n_errors = 0;
   int num_checks = 0;
   // 20 MHz system clock
   always #25 clk_sys = ~clk_sys;
   fct_cpu_model m (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
   fct_timer uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .low_power_entry(lp),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .capture_pin_first(cp1), .capture_pin_second(cp2),
      .capture_pin_third(cp3), .capture_pin_fourth(cp4), .ext_count_pin(ext),
      .compare_pin_first(pin1), .compare_pin_second(pin2), .timer_irq(irq));
   // Ticks expected over a window, upper bound one more for phase
   function automatic logic [15:0] ticks(input int cyc, input int k);
      return 16'(cyc / (2 << (2 * k)));
   endfunction : ticks
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_in(input string nm, input logic [15:0] lo, input logic [15:0] g);
      num_checks++;
      if ((g >= lo && g <= lo + 16'h0001) !== 1'b1) begin
         n_errors++;
         $display("ERROR %s exp %h got %h", nm, lo, g);
      end
   endtask : chk_in
   // Bounded wait for the first compare pin to go high
   task automatic wait_pin;
      for (int i = 0; i < 400; i++) begin
         @(posedge clk_sys);
         if (pin1 === 1'b1) return;
      end
      chk("wait_pin", 16'h0001, 16'h0000);
      tally_and_finish();
   endtask : wait_pin
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      m.rd8(4'hd, x); chk("edge_ctrl", 16'h0000, x);
      m.rd8(4'he, x); chk("out_ctrl", 16'h00e0, x);
      m.rd8(4'hf, x); chk("flags", 16'h0000, x);
      chk("pins", 16'h0000, {pin1, pin2});
      m.wr8(4'he, 8'h00);
      m.rd8(4'he, x); chk("out_fixed", 16'h00e0, x);
      // Shared compare address, select bit picks the value
      a = 16'($random(seed));
      b = 16'($random(seed));
      m.wr16(4'h2, a);
      m.wr8(4'he, 8'h10);
      m.wr16(4'h2, b);
      m.rd16(4'h2, w); chk("cmp_second", b, w);
      m.wr8(4'he, 8'h00);
      m.rd8(4'h0, x);
      m.rd8(4'h3, x); chk("cmp_lo_direct", {8'h00, a[7:0]}, x);
      m.rd16(4'h2, w); chk("cmp_first", a, w);
      // Prescaled rates over a 100-cycle window between upper-byte samples
      for (int k = 0; k < 3; k++) begin
         m.wr8(4'hd, 8'(k));
         m.wr16(4'h0, 16'($random(seed)));
         m.rd16(4'h0, w);
         repeat (96) @(posedge clk_sys);
         m.rd16(4'h0, w2);
         chk_in("rate", ticks(100, k), w2 - w);
      end
      // External source counts rising edges only
      m.wr8(4'hd, 8'h03);
      m.wr16(4'h0, 16'h0000);
      repeat (5) begin
         ext <= 1'b1;
         repeat (4) @(posedge clk_sys);
         ext <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      m.rd16(4'h0, w); chk("ext_count", 16'h0005, w);
      // Compare first with clear-on-match, pin drive and high level
      m.wr8(4'hd, 8'h00);
      m.wr8(4'hc, 8'h08);
      m.wr8(4'hf, 8'h01);
      // Second compare at 0008 with high level, its pin left undriven
      m.wr8(4'he, 8'h10);
      m.wr16(4'h2, 16'h0008);
      m.wr8(4'he, 8'h00);
      m.wr16(4'h2, 16'h0010);
      m.wr16(4'h0, 16'h0000);
      m.wr8(4'he, 8'h0b);
      wait_pin();
      m.rd16(4'h0, w); chk_in("cleared", 16'h0000, {12'h000, w[15:4] != 0, 3'h0});
      m.rd8(4'hf, x); chk("match_flag", 16'h0001, x[`FCT_FLAG_MATCH_FIRST]);
      chk("irq", 16'h0001, irq);
      chk("pin_off", 16'h0000, pin2);
      m.wr8(4'hf, 8'hff);
      m.rd8(4'hf, x); chk("set_by_one", 16'h0000, x[6]);
      m.wr16(4'h2, 16'h8000);
      m.wr8(4'hf, 8'h00);
      m.rd8(4'hf, x); chk("clr_by_zero", 16'h0000, x[`FCT_FLAG_MATCH_FIRST]);
      // Wrap from ffff to 0000
      m.wr16(4'h0, 16'hfff0);
      for (int i = 0; i < 40 && x[`FCT_FLAG_WRAP] !== 1'b1; i++) m.rd8(4'hf, x);
      chk("wrap_flag", 16'h0001, x[`FCT_FLAG_WRAP]);
      // Rising capture on first, buffered second, falling on fourth
      m.wr8(4'hd, 8'h86);
      m.rd16(4'h0, w2);
      cp1 <= 1'b1;
      cp4 <= 1'b0;
      repeat (6) @(posedge clk_sys);
      m.rd16(4'h4, w); chk_in("cap_first", w2, w);
      m.rd16(4'ha, a); chk("cap_fourth", 16'h0000, a);
      m.rd8(4'hf, x); chk("cap_flags", 16'h0009, {x[7:4]});
      m.wr8(4'hd, 8'h8e);
      cp1 <= 1'b0;
      cp2 <= 1'b1;
      repeat (6) @(posedge clk_sys);
      m.rd16(4'h4, a); chk("no_fall_cap", w, a);
      cp1 <= 1'b1;
      cp2 <= 1'b0;
      repeat (6) @(posedge clk_sys);
      m.rd16(4'h8, a); chk("buffered", w, a);
      m.rd8(4'hf, x); chk("cap_second_flag", 16'h0001, x[6]);
      // Low-power entry restores control registers
      lp <= 1'b1;
      @(posedge clk_sys);
      lp <= 1'b0;
      m.rd8(4'hd, x); chk("lp_edge_ctrl", 16'h0000, x);
      m.rd8(4'he, x); chk("lp_out_ctrl", 16'h00e0, x);
      tally_and_finish();
   end
endmodule : fct_timer_tb
